// *** sfpe_regs.vh ***
`ifndef SFPE_REGS_VH
`define SFPE_REGS_VH

// Instruction codes
`define SFPE_OP_WRITE_ENABLE_COMMAND      8'h06
`define SFPE_OP_RDSR      8'h05
`define SFPE_OP_PROG      8'h02
`define SFPE_OP_QPROG     8'h33
`define SFPE_OP_ERASE4K   8'h20
`define SFPE_OP_ERASE32K  8'h52
`define SFPE_OP_ERASE64K  8'hD8
`define SFPE_OP_CHIP_A    8'hC7
`define SFPE_OP_CHIP_B    8'h60

// Status byte fields
`define SFPE_ST_BUSY_BIT  0
`define SFPE_ST_WEL_BIT   1
`define SFPE_ST_RESET     8'h00

// Array operation kinds
`define SFPE_K_PROG       3'h0
`define SFPE_K_ERASE4K    3'h1
`define SFPE_K_ERASE32K   3'h2
`define SFPE_K_ERASE64K   3'h3
`define SFPE_K_CHIP       3'h4

// Block base masks
`define SFPE_MASK_4K      24'hFFF000
`define SFPE_MASK_32K     24'hFF8000
`define SFPE_MASK_64K     24'hFF0000
`define SFPE_PAGE_MASK    24'hFFFF00

// Timing, system clock 40 MHz
`define SFPE_CLK_KHZ      40000
`define SFPE_T_PROG_US    1000
`define SFPE_T_SMALL_MS   100
`define SFPE_T_MEDIUM_MS  300
`define SFPE_T_LARGE_MS   500
`define SFPE_T_FULL_MS    20000
`define SFPE_PROG_CYC     (`SFPE_T_PROG_US * `SFPE_CLK_KHZ / 1000)
`define SFPE_SMALL_CYC    (`SFPE_T_SMALL_MS * `SFPE_CLK_KHZ)
`define SFPE_MEDIUM_CYC   (`SFPE_T_MEDIUM_MS * `SFPE_CLK_KHZ)
`define SFPE_LARGE_CYC    (`SFPE_T_LARGE_MS * `SFPE_CLK_KHZ)
`define SFPE_FULL_CYC     (`SFPE_T_FULL_MS * `SFPE_CLK_KHZ)

`endif

// *** sfpe_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sfpe_regs.vh"

module sfpe_top #(
   parameter [31:0] PROG_CYC   = `SFPE_PROG_CYC,
   parameter [31:0] SMALL_CYC  = `SFPE_SMALL_CYC,
   parameter [31:0] MEDIUM_CYC = `SFPE_MEDIUM_CYC,
   parameter [31:0] LARGE_CYC  = `SFPE_LARGE_CYC,
   parameter [31:0] FULL_CYC   = `SFPE_FULL_CYC
) (
   input  wire        CLK_SYS,
   input  wire        RESET,
   input  wire        CLK_EN,
   input  wire        SCK,
   input  wire        CS_N,
   input  wire [3:0]  IO_IN,
   output reg  [3:0]  IO_OUT,
   output reg  [3:0]  IO_OE,
   input  wire        QUAD_ENABLE_BIT,
   output reg         BUSY,
   output reg         WRITE_ENABLE_LATCH,
   output reg         ARR_VALID,
   input  wire        ARR_READY,
   output reg  [2:0]  ARR_KIND,
   output reg  [23:0] ARR_ADDR,
   output reg  [7:0]  ARR_DATA
);

   localparam [5:0] RX_OPC = 6'h01;
   localparam [5:0] RX_ADR = 6'h02;
   localparam [5:0] RX_DAT = 6'h04;
   localparam [5:0] RX_STA = 6'h08;
   localparam [5:0] RX_END = 6'h10;
   localparam [5:0] RX_IGN = 6'h20;
   localparam [2:0] EX_IDLE  = 3'h1;
   localparam [2:0] EX_DRAIN = 3'h2;
   localparam [2:0] EX_WAIT  = 3'h4;
   // Two-flop synchronisers, third stage only for edge detection
   reg        sck_s1_q, sck_s2_q, sck_s3_q;
   reg        cs_s1_q,  cs_s2_q,  cs_s3_q;
   reg [3:0]  io_s1_q,  io_s2_q;
   reg [5:0]  rx_q;
   reg [4:0]  cnt_q;
   reg [7:0]  opc_q;
   reg [23:0] addr_q;
   reg [7:0]  dsh_q;
   reg        quad_q;
   reg        exe_q;
   reg        nbyte_q;
   reg [2:0]  kind_q;
   reg [7:0]  ptr_q;
   reg [7:0]  sr_q;
   reg [2:0]  scnt_q;
   reg [7:0]  pbuf [0:255];
   reg [255:0] pvalid_q;
   reg [2:0]  ex_q;
   reg [31:0] timer_q;
   reg [7:0]  idx_q;
   reg        spare_v_q;
   reg [34:0] spare_q;
   wire       sck_rise = sck_s2_q & ~sck_s3_q;
   wire       sck_fall = ~sck_s2_q & sck_s3_q;
   wire       cs_fall  = ~cs_s2_q & cs_s3_q;
   wire       cs_rise  = cs_s2_q & ~cs_s3_q;
   wire       sel      = ~cs_s2_q;
   wire [7:0] stat     = {6'h00, WRITE_ENABLE_LATCH, BUSY};
   wire [7:0]  opc_n   = {opc_q[6:0], io_s2_q[0]};
   wire [23:0] addr_n  = quad_q ? {addr_q[19:0], io_s2_q} : {addr_q[22:0], io_s2_q[0]};
   wire [7:0]  dsh_n   = quad_q ? {dsh_q[3:0], io_s2_q} : {dsh_q[6:0], io_s2_q[0]};
   wire [4:0]  adr_last = quad_q ? 5'h05 : 5'h17;
   wire [4:0]  dat_last = quad_q ? 5'h01 : 5'h07;
   // Frame may execute only when it ended exactly on a byte boundary
   wire frame_ok = exe_q & ((rx_q == RX_END) |
                   ((rx_q == RX_DAT) & (cnt_q == 5'h00) & nbyte_q));
   // Buffer input
   wire        in_rdy  = ~spare_v_q;
   wire        drain_push = (ex_q == EX_DRAIN) & pvalid_q[idx_q] & in_rdy;
   wire        erase_push = (ex_q == EX_WAIT) & (kind_q != `SFPE_K_PROG) & (timer_q != 32'h0) & exe_q & in_rdy;
   wire        push    = drain_push | erase_push;
   wire        pop     = ARR_VALID & ARR_READY;
   reg  [34:0] in_word;
   function [31:0] cyc_of;
      input [2:0] k;
      begin
         case (k)
            `SFPE_K_PROG:     cyc_of = PROG_CYC;
            `SFPE_K_ERASE4K:  cyc_of = SMALL_CYC;
            `SFPE_K_ERASE32K: cyc_of = MEDIUM_CYC;
            `SFPE_K_ERASE64K: cyc_of = LARGE_CYC;
            default:          cyc_of = FULL_CYC;
         endcase
      end
   endfunction
   function [23:0] base_of;
      input [2:0]  k;
      input [23:0] a;
      begin
         case (k)
            `SFPE_K_ERASE4K:  base_of = a & `SFPE_MASK_4K;
            `SFPE_K_ERASE32K: base_of = a & `SFPE_MASK_32K;
            `SFPE_K_ERASE64K: base_of = a & `SFPE_MASK_64K;
            default:          base_of = 24'h000000;
         endcase
      end
   endfunction
   always @* begin
      if (drain_push)
         in_word = {`SFPE_K_PROG, (addr_q & `SFPE_PAGE_MASK) | {16'h0000, idx_q}, pbuf[idx_q]};
      else
         in_word = {kind_q, base_of(kind_q, addr_q), 8'hFF};
   end
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         {sck_s3_q, sck_s2_q, sck_s1_q} <= 3'h0;
         {cs_s3_q, cs_s2_q, cs_s1_q}    <= 3'h7;
         {io_s2_q, io_s1_q}             <= 8'h00;
      end else if (CLK_EN) begin
         {sck_s3_q, sck_s2_q, sck_s1_q} <= {sck_s2_q, sck_s1_q, SCK};
         {cs_s3_q, cs_s2_q, cs_s1_q}    <= {cs_s2_q, cs_s1_q, CS_N};
         {io_s2_q, io_s1_q}             <= {io_s1_q, IO_IN};
      end
   end
   // Instruction receiver and page loader
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         rx_q     <= RX_IGN;
         cnt_q    <= 5'h00;
         opc_q    <= 8'h00;
         addr_q   <= 24'h000000;
         dsh_q    <= 8'h00;
         quad_q   <= 1'b0;
         exe_q    <= 1'b0;
         nbyte_q  <= 1'b0;
         kind_q   <= `SFPE_K_PROG;
         ptr_q    <= 8'h00;
         sr_q     <= `SFPE_ST_RESET;
         scnt_q   <= 3'h0;
         pvalid_q <= 256'h0;
         IO_OUT   <= 4'h0;
         IO_OE    <= 4'h0;
         BUSY     <= 1'b0;
         WRITE_ENABLE_LATCH <= 1'b0;
         ex_q     <= EX_IDLE;
         timer_q  <= 32'h0;
         idx_q    <= 8'h00;
      end else if (CLK_EN) begin
         if (cs_fall) begin
            rx_q    <= RX_OPC;
            cnt_q   <= 5'h00;
            quad_q  <= 1'b0;
            exe_q   <= 1'b0;
            nbyte_q <= 1'b0;
         end else if (cs_rise) begin
            rx_q  <= RX_IGN;
            IO_OE <= 4'h0;
            if (frame_ok && !BUSY) begin
               BUSY    <= 1'b1;
               WRITE_ENABLE_LATCH <= 1'b0;
               timer_q <= cyc_of(kind_q);
               idx_q   <= 8'h00;
               ex_q    <= (kind_q == `SFPE_K_PROG) ? EX_DRAIN : EX_WAIT;
            end else begin
               exe_q <= 1'b0;
            end
         end else if (sel && sck_rise) begin
            case (rx_q)
               RX_OPC: begin
                  opc_q <= opc_n;
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == 5'h07) begin
                     cnt_q <= 5'h00;
                     rx_q  <= RX_IGN;
                     case (opc_n)
                        `SFPE_OP_WRITE_ENABLE_COMMAND: begin
                           if (!BUSY)
                              WRITE_ENABLE_LATCH <= 1'b1;
                        end
                        `SFPE_OP_RDSR: begin
                           rx_q   <= RX_STA;
                           scnt_q <= 3'h0;
                        end
                        `SFPE_OP_PROG, `SFPE_OP_QPROG: begin
                           if (WRITE_ENABLE_LATCH && !BUSY &&
                               (opc_n != `SFPE_OP_QPROG || QUAD_ENABLE_BIT)) begin
                              rx_q   <= RX_ADR;
                              quad_q <= (opc_n == `SFPE_OP_QPROG);
                              kind_q <= `SFPE_K_PROG;
                              exe_q  <= 1'b1;
                           end
                        end
                        `SFPE_OP_ERASE4K, `SFPE_OP_ERASE32K, `SFPE_OP_ERASE64K: begin
                           if (WRITE_ENABLE_LATCH && !BUSY) begin
                              rx_q   <= RX_ADR;
                              exe_q  <= 1'b1;
                              kind_q <= (opc_n == `SFPE_OP_ERASE4K)  ? `SFPE_K_ERASE4K :
                                        (opc_n == `SFPE_OP_ERASE32K) ? `SFPE_K_ERASE32K :
                                                                       `SFPE_K_ERASE64K;
                           end
                        end
                        `SFPE_OP_CHIP_A, `SFPE_OP_CHIP_B: begin
                           if (WRITE_ENABLE_LATCH && !BUSY) begin
                              rx_q   <= RX_END;
                              kind_q <= `SFPE_K_CHIP;
                              exe_q  <= 1'b1;
                           end
                        end
                        default: rx_q <= RX_IGN;
                     endcase
                  end
               end
               RX_ADR: begin
                  addr_q <= addr_n;
                  cnt_q  <= cnt_q + 5'h01;
                  if (cnt_q == adr_last) begin
                     cnt_q <= 5'h00;
                     if (kind_q == `SFPE_K_PROG) begin
                        rx_q     <= RX_DAT;
                        ptr_q    <= addr_n[7:0];
                        pvalid_q <= 256'h0;
                     end else begin
                        rx_q <= RX_END;
                     end
                  end
               end
               RX_DAT: begin
                  dsh_q <= dsh_n;
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == dat_last) begin
                     cnt_q           <= 5'h00;
                     nbyte_q         <= 1'b1;
                     pbuf[ptr_q]     <= dsh_n;
                     pvalid_q[ptr_q] <= 1'b1;
                     ptr_q           <= ptr_q + 8'h01;
                  end
               end
               RX_STA: ;
               // Any clock past the last address bit (chip erase: last opcode bit) spoils the erase
               RX_END: begin
                  rx_q  <= RX_IGN;
                  exe_q <= 1'b0;
               end
               default: rx_q <= RX_IGN;
            endcase
         end else if (sel && sck_fall && rx_q == RX_STA) begin
            // Status streams out on IO1, refreshed every byte
            IO_OE  <= 4'h2;
            scnt_q <= scnt_q + 3'h1;
            if (scnt_q == 3'h0) begin
               IO_OUT <= {2'b00, stat[7], 1'b0};
               sr_q   <= {stat[6:0], 1'b0};
            end else begin
               IO_OUT <= {2'b00, sr_q[7], 1'b0};
               sr_q   <= {sr_q[6:0], 1'b0};
            end
         end
         // Self-timed execution
         if (BUSY) begin
            if (timer_q != 32'h0 && !(ex_q == EX_WAIT && exe_q && kind_q != `SFPE_K_PROG))
               timer_q <= timer_q - 32'h1;
            case (ex_q)
               EX_DRAIN: begin
                  if (!pvalid_q[idx_q] || in_rdy) begin
                     idx_q <= idx_q + 8'h01;
                     if (idx_q == 8'hFF)
                        ex_q <= EX_WAIT;
                  end
               end
               EX_WAIT: begin
                  if (erase_push)
                     exe_q <= 1'b0;
                  if (timer_q == 32'h0 && !ARR_VALID && !spare_v_q && !exe_q) begin
                     BUSY <= 1'b0;
                     ex_q <= EX_IDLE;
                  end
                  if (timer_q == 32'h0 && kind_q == `SFPE_K_PROG)
                     exe_q <= 1'b0;
               end
               default: ex_q <= EX_IDLE;
            endcase
         end
      end
   end
   // Two-entry buffer toward the array; output stage is the head
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         ARR_VALID <= 1'b0;
         ARR_KIND  <= 3'h0;
         ARR_ADDR  <= 24'h000000;
         ARR_DATA  <= 8'h00;
         spare_v_q <= 1'b0;
         spare_q   <= 35'h0;
      end else if (CLK_EN) begin
         // A push needs an empty spare stage, so no word is ever dropped
         ARR_VALID <= push | spare_v_q | (ARR_VALID & ~pop);
         spare_v_q <= spare_v_q ? ~pop : (push & ARR_VALID & ~pop);
         if (pop && spare_v_q)
            {ARR_KIND, ARR_ADDR, ARR_DATA} <= spare_q;
         else if (push && (pop || !ARR_VALID))
            {ARR_KIND, ARR_ADDR, ARR_DATA} <= in_word;
         if (push && ARR_VALID && !pop)
            spare_q <= in_word;
      end
   end
endmodule
`default_nettype wire

// *** sfpe_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfpe_chk #(
   parameter [31:0] PROG_CYC = 32'h9C40
) (
   input wire logic        CLK_SYS,
   input wire logic        RESET,
   input wire logic        CS_N,
   input wire logic        BUSY,
   input wire logic        WRITE_ENABLE_LATCH,
   input wire logic        ARR_VALID,
   input wire logic        ARR_READY,
   input wire logic [2:0]  ARR_KIND,
   input wire logic [23:0] ARR_ADDR,
   input wire logic [7:0]  ARR_DATA
);
   logic [31:0] busy_cnt_q;
   // Cycles spent busy, read at the falling edge of busy
   always @(posedge CLK_SYS) begin
      if (RESET || !BUSY) busy_cnt_q <= 32'h0;
      else busy_cnt_q <= busy_cnt_q + 32'h1;
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   sequence s_start;
      !BUSY ##1 BUSY;
   endsequence
   property p_clr_wel; s_start |-> ##[0:1] !WRITE_ENABLE_LATCH; endproperty
   a_clr_wel: assert property (p_clr_wel) else $error("latch kept at busy start");
   property p_after_frame; s_start |-> CS_N && $past(CS_N, 2); endproperty
   a_after_frame: assert property (p_after_frame) else $error("busy rose inside a frame");
   property p_needs_wel; s_start |-> $past(WRITE_ENABLE_LATCH); endproperty
   a_needs_wel: assert property (p_needs_wel) else $error("cycle started without latch");
   property p_busy_len; $fell(BUSY) |-> busy_cnt_q >= PROG_CYC - 32'h2; endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy too short");
   property p_arr_busy; ARR_VALID |-> BUSY; endproperty
   a_arr_busy: assert property (p_arr_busy) else $error("array word while idle");
   property p_arr_hold;
      ARR_VALID && !ARR_READY |=> ARR_VALID && $stable({ARR_KIND, ARR_ADDR, ARR_DATA});
   endproperty
   a_arr_hold: assert property (p_arr_hold) else $error("stalled word changed");
   property p_erase_ff; ARR_VALID && ARR_KIND != 3'h0 |-> ARR_DATA == 8'hFF; endproperty
   a_erase_ff: assert property (p_erase_ff) else $error("erase data not all ones");
   property p_blk_base; ARR_VALID && ARR_KIND == 3'h3 |-> ARR_ADDR[15:0] == 16'h0; endproperty
   a_blk_base: assert property (p_blk_base) else $error("large block base unaligned");
endmodule
bind sfpe_top sfpe_chk #(.PROG_CYC(PROG_CYC)) i_chk (.CLK_SYS, .RESET, .CS_N, .BUSY,
   .WRITE_ENABLE_LATCH, .ARR_VALID, .ARR_READY, .ARR_KIND, .ARR_ADDR, .ARR_DATA);
`default_nettype wire

// *** sfpe_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfpe_host (
   input  wire logic       CLK_SYS,
   input  wire logic [3:0] IO_OUT,
   input  wire logic [3:0] IO_OE,
   output logic            SCK,
   output logic            CS_N,
   output logic [3:0]      IO_IN
);
   logic [3:0] drv_q;
   // Wire level: device wins where it drives
   assign IO_IN = (IO_OE & IO_OUT) | (~IO_OE & drv_q);
   initial begin
      SCK = 1'b0;
      CS_N = 1'b1;
      drv_q = 4'hA;
   end
   task hp;
      repeat (4) @(posedge CLK_SYS);
      #1;
   endtask
   task start;
      CS_N = 1'b0;
      hp;
   endtask
   task clk1(input logic [3:0] v, output logic r);
      drv_q = v;
      hp;
      SCK = 1'b1;
      hp;
      r = IO_IN[1];
      SCK = 1'b0;
   endtask
   task byte1(input logic [7:0] b, output logic [7:0] r);
      int i;
      for (i = 7; i >= 0; i--) clk1({~b[i], ~b[i], ~b[i], b[i]}, r[i]);
   endtask
   // Clock stays low between frames; released lines show inverted data
   task stop;
      hp;
      CS_N = 1'b1;
      drv_q = ~drv_q;
      hp;
   endtask
endmodule
`default_nettype wire

// *** sfpe_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sfpe_regs.vh"
module tb;
   localparam [31:0] PC = 32'h190;
   logic             clk_sys = 1'b0;
   logic             reset = 1'b1;
   logic             qe = 1'b0;
   logic             rdy = 1'b0;
   wire logic        sck, cs_n, busy, write_enable_latch, arr_valid;
   wire logic [3:0]  io_in, io_out, io_oe;
   wire logic [2:0]  arr_kind;
   wire logic [23:0] arr_addr;
   wire logic [7:0]  arr_data;
   int               mismatches = 0;
   int               cmp_count = 0;
   int               cyc = 0;
   logic             wel_m = 1'b0;
   logic [34:0]      q_exp[$];
   logic [7:0]       pg[256];
   bit               ld[256];
   logic [7:0]       ops[5] = '{`SFPE_OP_ERASE4K, `SFPE_OP_ERASE32K, `SFPE_OP_ERASE64K,
                               `SFPE_OP_CHIP_A, `SFPE_OP_CHIP_B};
   always #12.5 clk_sys = ~clk_sys;
   sfpe_top #(.PROG_CYC(PC), .SMALL_CYC(PC + 32'hA), .MEDIUM_CYC(PC + 32'h14),
      .LARGE_CYC(PC + 32'h1E), .FULL_CYC(PC + 32'h28)) i_dut (.CLK_SYS(clk_sys), .RESET(reset),
      .CLK_EN(1'b1), .SCK(sck), .CS_N(cs_n), .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe),
      .QUAD_ENABLE_BIT(qe), .BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch), .ARR_VALID(arr_valid),
      .ARR_READY(rdy), .ARR_KIND(arr_kind), .ARR_ADDR(arr_addr), .ARR_DATA(arr_data));
   sfpe_host i_host (.CLK_SYS(clk_sys), .IO_OUT(io_out), .IO_OE(io_oe), .SCK(sck), .CS_N(cs_n),
      .IO_IN(io_in));
   task final_report;
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk_v(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %0h got %0h", n, e, g);
      end
   endtask
   task chk_w(input logic [34:0] g);
      logic [34:0] e;
      e = (q_exp.size() > 0) ? q_exp.pop_front() : {35{1'bx}};
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("BAD array_word exp %0h got %0h", e, g);
      end
   endtask
   // Array sink stalls at random; every accepted word is checked
   always @(posedge clk_sys) begin
      rdy <= #1 (($urandom % 4) != 0);
      cyc <= cyc + 1;
      if (arr_valid === 1'b1 && rdy === 1'b1) chk_w({arr_kind, arr_addr, arr_data});
      if (cyc == 60000) begin
         mismatches++;
         final_report;
      end
   end
   task clks(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task write_enable_command;
      logic [7:0] r;
      i_host.start();
      i_host.byte1(`SFPE_OP_WRITE_ENABLE_COMMAND, r);
      i_host.stop();
      clks(2);
      wel_m = 1'b1;
      chk_v("wel", wel_m, write_enable_latch);
   endtask
   task act(input logic [7:0] op, input logic [23:0] a, input int n, input int xb);
      logic [7:0]  d, r;
      logic [2:0]  k;
      logic [23:0] m;
      logic        go;
      int          i;
      k = `SFPE_K_PROG;
      m = 24'hFFFFFF;
      case (op)
         `SFPE_OP_ERASE4K: begin k = `SFPE_K_ERASE4K; m = `SFPE_MASK_4K; end
         `SFPE_OP_ERASE32K: begin k = `SFPE_K_ERASE32K; m = `SFPE_MASK_32K; end
         `SFPE_OP_ERASE64K: begin k = `SFPE_K_ERASE64K; m = `SFPE_MASK_64K; end
         `SFPE_OP_CHIP_A, `SFPE_OP_CHIP_B: begin k = `SFPE_K_CHIP; m = 24'h0; end
         default: ;
      endcase
      for (i = 0; i < 256; i++) ld[i] = 1'b0;
      i_host.start();
      i_host.byte1(op, r);
      if (op == `SFPE_OP_QPROG) for (i = 5; i >= 0; i--) i_host.clk1(a[i*4 +: 4], r[0]);
      else if (k != `SFPE_K_CHIP) for (i = 2; i >= 0; i--) i_host.byte1(a[i*8 +: 8], r);
      for (i = 0; i < n; i++) begin
         d = 8'($urandom);
         if (op == `SFPE_OP_QPROG) begin
            i_host.clk1(d[7:4], r[0]);
            i_host.clk1(d[3:0], r[0]);
         end else i_host.byte1(d, r);
         pg[(a[7:0] + i) % 256] = d;
         ld[(a[7:0] + i) % 256] = 1'b1;
      end
      for (i = 0; i < xb; i++) i_host.clk1(4'h5, r[0]);
      i_host.stop();
      go = wel_m && xb == 0 && (k != `SFPE_K_PROG || n > 0) && (op != `SFPE_OP_QPROG || qe);
      if (go) begin
         wel_m = 1'b0;
         if (k != `SFPE_K_PROG) q_exp.push_back({k, a & m, 8'hFF});
         else for (i = 0; i < 256; i++) if (ld[i]) q_exp.push_back({k, a[23:8], i[7:0], pg[i]});
         clks(8);
         chk_v("busy", 1, busy);
         chk_v("wel", 0, write_enable_latch);
         rd_st(d);
         chk_v("status", 8'h01, d);
         i = 0;
         while (busy !== 1'b0 && i < 2000) begin
            clks(1);
            i++;
         end
         chk_v("done", 0, busy);
         chk_v("drained", 0, q_exp.size());
      end else begin
         clks(20);
         chk_v("idle", 0, busy);
         chk_v("wel", wel_m, write_enable_latch);
      end
   endtask
   task rd_st(output logic [7:0] s);
      logic [7:0] r;
      i_host.start();
      i_host.byte1(`SFPE_OP_RDSR, r);
      i_host.byte1(8'h00, s);
      i_host.stop();
      chk_v("oe", 4'h0, io_oe);
   endtask
   initial begin
      void'($urandom(45));
      clks(10);
      reset = 1'b0;
      clks(4);
      act(`SFPE_OP_PROG, 24'h001234, 4, 0);
      tdone("no latch");
      write_enable_command;
      act(`SFPE_OP_PROG, 24'h0123F0, 20, 0);
      tdone("wrap");
      write_enable_command;
      act(`SFPE_OP_PROG, 24'h045600, 258, 0);
      tdone("overrun");
      write_enable_command;
      act(`SFPE_OP_PROG, 24'h000010, 1, 3);
      act(`SFPE_OP_PROG, 24'h000010, 0, 0);
      act(`SFPE_OP_QPROG, 24'h0007FE, 5, 0);
      tdone("refused");
      qe = 1'b1;
      act(`SFPE_OP_QPROG, 24'($urandom), 9, 0);
      tdone("quad");
      foreach (ops[j]) begin
         write_enable_command;
         act(ops[j], 24'($urandom), 0, 1);
         act(ops[j], 24'($urandom), 0, 0);
         tdone("erase");
      end
      final_report;
   end
   task tdone(input string n);
      $display("test %s ended, mismatches %0d", n, mismatches);
   endtask
endmodule
`default_nettype wire
